// ### verilog/rbc_pkg.sv
package rbc_pkg;
    // register addresses, as seen in the serial command byte
    localparam logic [5:0] ADDR_CODE_FIRST = 6'h11;
    localparam logic [5:0] ADDR_CODE_LAST  = 6'h18;
    localparam logic [5:0] ADDR_THR_LOW    = 6'h19;
    localparam logic [5:0] ADDR_THR_HIGH   = 6'h1A;
    localparam logic [5:0] ADDR_WAKE_EN    = 6'h1C;
    localparam logic [5:0] ADDR_WAKE_STAT  = 6'h1D;
    localparam logic [5:0] ADDR_ANALOG     = 6'h20;
    localparam logic [5:0] ADDR_CHANNEL    = 6'h21;
    localparam logic [5:0] ADDR_STRENGTH   = 6'h22;
    localparam logic [5:0] ADDR_AMP_BIAS   = 6'h23;
    localparam logic [5:0] ADDR_CRYSTAL    = 6'h24;
    localparam logic [5:0] ADDR_PWR_CTL    = 6'h2E;
    localparam logic [5:0] ADDR_CARRIER    = 6'h2F;
    localparam logic [5:0] ADDR_MID_FIRST  = 6'h3C;
    localparam logic [5:0] ADDR_MID_LAST   = 6'h3F;

    // reset values
    localparam logic [63:0] RST_CODE      = 64'h0000_0000_0000_0000;
    localparam logic [6:0]  RST_THR_LOW   = 7'h08;
    localparam logic [6:0]  RST_THR_HIGH  = 7'h38;
    localparam logic        RST_WAKE_STAT = 1'h1;
    localparam logic [7:0]  RST_BYTE      = 8'h00;

    // field positions
    localparam int ANA_WRITE_UNLOCK = 6;
    localparam int ANA_MID_READ     = 5;
    localparam int ANA_AMP_OE       = 2;
    localparam int ANA_AMP_INV      = 1;
    localparam int ANA_SOFT_RST     = 0;
    localparam int XTAL_CLK_OFF     = 6;
    localparam int CMD_WRITE        = 7;
    localparam int CMD_INC          = 6;

    // field masks for writable bits
    localparam logic [7:0] MASK_7BIT   = 8'h7F;
    localparam logic [7:0] MASK_WAKE   = 8'h01;
    localparam logic [7:0] MASK_ANALOG = 8'h66;
    localparam logic [7:0] MASK_BIAS   = 8'h07;
    localparam logic [7:0] MASK_TOPBIT = 8'h80;

    // chip counting and synthesizer base
    localparam logic [5:0]  CHIP_LAST_FULL = 6'h3F;
    localparam logic [5:0]  CHIP_LAST_HALF = 6'h1F;
    localparam logic [5:0]  CHIP_HIGH_BASE = 6'h20;
    localparam logic [11:0] SYNTH_BASE_MHZ = 12'h960;

    typedef enum logic [1:0] {
        RBC_CODE_FULL = 2'b00,
        RBC_CODE_LOW  = 2'b01,
        RBC_CODE_HIGH = 2'b10,
        RBC_CODE_DUAL = 2'b11
    } rbc_code_mode_type;

    typedef enum logic [0:0] {
        RBC_TX_IDLE = 1'b0,
        RBC_TX_RUN  = 1'b1
    } rbc_tx_state_type;

    // one serial register access handed to the core clock
    typedef struct packed {
        logic       write;
        logic [5:0] addr;
        logic [7:0] data;
    } rbc_req_type;
endpackage

// ### verilog/rbc_regs.sv
// Notes on behaviour
// - spreading code is 64 chips per bit, or two 32-chip halves alone/alternating
// - chips go out from code bit 0 upward to bit 63
// - each bit time sends data if its valid bit is 1, else preamble, LSB first
// - serializer runs until no valid bits remain in its shifter
// - 7-bit low threshold, reset 0x08, most matches still read as zero
// - 7-bit high threshold, reset 0x38, least matches read as one
// - count at/above high gives one, at/below low gives zero
// - wake enable bit 0 gates the wakeup interrupt, resets to zero
// - wakeup event when power-down is released and the second and third synchronizer stages agree
// - wake status sets on wakeup, resets to 1, clears when read
// - analog bit 6 unlocks writes to 0x2E and 0x2F, else read-only
// - identity registers read only while analog bit 5 is set
// - analog bit 2 enables driving the amplifier control pin
// - analog bit 1 sets amplifier pin polarity, 1 is active low
// - 7-bit channel sets synthesizer in 1 MHz steps, 2 is 2402 MHz
// - strength register gives 5-bit value and a valid flag in bit 5
// - 3-bit amplifier bias sets transmit power, higher is stronger
// - crystal bit 6 stops the buffered clock output, enabled at reset
// - 6-bit crystal field sets load capacitance trim
module rbc_regs #(
    parameter logic [29:0] MID_VALUE = 30'h0123_4567 // arbitrary identity
) (
    input  wire logic                       clk_i,
    input  wire logic                       srst_i,
    input  wire logic                       spi_sck_i,
    input  wire logic                       spi_ss_n_i,
    input  wire logic                       spi_mosi_i,
    output logic                            spi_miso_o,
    output logic                            spi_miso_oe_o,
    input  wire logic                       power_down_input_n_i,
    input  wire rbc_pkg::rbc_code_mode_type code_mode_i,
    input  wire logic                       tx_load_i,
    input  wire logic [7:0]                 tx_byte_i,
    input  wire logic [7:0]                 tx_valid_i,
    output logic                            tx_ready_o,
    output logic                            tx_chip_o,
    output logic                            tx_busy_o,
    input  wire logic [6:0]                 corr_count_i,
    input  wire logic                       corr_count_valid_i,
    output logic                            rx_bit_o,
    output logic                            rx_bit_valid_o,
    output logic                            rx_bit_miss_o,
    input  wire logic [4:0]                 signal_strength_value_i,
    input  wire logic                       signal_strength_valid_i,
    output logic [63:0]                     spreading_code_o,
    output logic [6:0]                      thr_low_o,
    output logic [6:0]                      thr_high_o,
    output logic                            wake_irq_o,
    output logic [6:0]                      rf_channel_o,
    output logic [11:0]                     synth_freq_mhz_o,
    output logic [2:0]                      power_amp_bias_o,
    output logic [5:0]                      crystal_trim_o,
    output logic                            buffered_clock_en_o,
    output logic                            ext_amp_control_pin_o,
    output logic                            ext_amp_control_pin_oe_o,
    output logic                            pwr_ctl_bit_o,
    output logic                            carrier_override_o
);
    // ---------------- link side, on the serial clock ----------------
    logic [2:0]           bit_cnt;
    logic                 first_byte;
    logic                 cmd_write;
    logic                 cmd_inc;
    logic [5:0]           cur_addr;
    logic [6:0]           shift_in;
    logic [6:0]           shift_out;
    logic                 req_tog = 1'b0;  // power-up value, no reset edge
    rbc_pkg::rbc_req_type req;
    logic [7:0]           rd_data;
    wire  [7:0]           rx_byte = {shift_in, spi_mosi_i};
    wire                  byte_end = (bit_cnt == 3'h7);

    // command byte then data bytes, msb first, mode 0
    always_ff @(posedge spi_sck_i or posedge spi_ss_n_i)
    begin
        if (spi_ss_n_i)
        begin
            bit_cnt    <= 3'h0;
            first_byte <= 1'b1;
            cmd_write  <= 1'b0;
            cmd_inc    <= 1'b0;
            cur_addr   <= 6'h00;
            shift_in   <= 7'h00;
        end
        else
        begin
            bit_cnt  <= bit_cnt + 3'h1;
            shift_in <= rx_byte[6:0];
            if (byte_end && first_byte)
            begin
                first_byte <= 1'b0;
                cmd_write  <= rx_byte[rbc_pkg::CMD_WRITE];
                cmd_inc    <= rx_byte[rbc_pkg::CMD_INC];
                cur_addr   <= rx_byte[5:0];
            end
            else if (byte_end && cmd_inc)
                cur_addr <= cur_addr + 6'h01;
        end
    end

    // each finished data byte becomes one request, flagged by a toggle
    always_ff @(posedge spi_sck_i)
    begin
        if (!spi_ss_n_i && byte_end && !first_byte)
        begin
            req     <= '{write: cmd_write, addr: cur_addr, data: rx_byte};
            req_tog <= ~req_tog;
        end
    end

    // read data launched on falling edges; register image is quasi-static
    always_ff @(negedge spi_sck_i or posedge spi_ss_n_i)
    begin
        if (spi_ss_n_i)
        begin
            spi_miso_o <= 1'b0;
            shift_out  <= 7'h00;
        end
        else if (bit_cnt == 3'h0 && !first_byte && !cmd_write)
        begin
            spi_miso_o <= rd_data[7];
            shift_out  <= rd_data[6:0];
        end
        else
        begin
            spi_miso_o <= shift_out[6];
            shift_out  <= {shift_out[5:0], 1'b0};
        end
    end

    // miso driven only inside a frame, from the first rising edge
    always_ff @(posedge spi_sck_i or posedge spi_ss_n_i)
    begin
        if (spi_ss_n_i)
            spi_miso_oe_o <= 1'b0;
        else
            spi_miso_oe_o <= 1'b1;
    end

    // ---------------- core side, on clk_i ----------------
    logic [2:0] tog_sync;
    logic       tog_seen;
    logic [2:0] pd_sync;
    logic       pd_stable;
    logic [7:0] code_q [8];
    logic [7:0] wake_en;
    logic       wake_stat;
    logic [7:0] analog;
    logic [7:0] crystal;
    logic [7:0] pwr_ctl;
    logic [7:0] carrier;

    // three-stage capture; second and third must agree
    always_ff @(posedge clk_i)
    begin
        tog_sync <= {tog_sync[1:0], req_tog};
        pd_sync  <= {pd_sync[1:0], power_down_input_n_i};
        if (srst_i)
        begin
            tog_seen  <= 1'b0;
            pd_stable <= 1'b0;
        end
        else
        begin
            if (tog_sync[1] == tog_sync[2])
                tog_seen <= tog_sync[2];
            if (pd_sync[1] == pd_sync[2])
                pd_stable <= pd_sync[2];
        end
    end

    wire req_ev = (tog_sync[1] == tog_sync[2]) && (tog_sync[2] != tog_seen);
    wire wr_ev  = req_ev && req.write;
    wire rd_ev  = req_ev && !req.write;
    wire soft_rst = wr_ev && (req.addr == rbc_pkg::ADDR_ANALOG)
                    && req.data[rbc_pkg::ANA_SOFT_RST];
    wire clr_all = srst_i || soft_rst;
    wire unlock  = analog[rbc_pkg::ANA_WRITE_UNLOCK];
    wire wake_ev = pd_sync[1] == pd_sync[2] && pd_sync[2] && !pd_stable;
    wire wake_rd = rd_ev && (req.addr == rbc_pkg::ADDR_WAKE_STAT);
    wire [5:0] code_idx = req.addr - rbc_pkg::ADDR_CODE_FIRST;
    wire       code_hit = (req.addr >= rbc_pkg::ADDR_CODE_FIRST)
                          && (req.addr <= rbc_pkg::ADDR_CODE_LAST);

    // spreading code bytes, byte 0x11 holds chips 7:0
    for (genvar g = 0; g < 8; g++)
    begin : g_code
        always_ff @(posedge clk_i)
        begin
            if (clr_all)
                code_q[g] <= rbc_pkg::RST_CODE[g*8 +: 8];
            else if (wr_ev && code_hit && code_idx[2:0] == 3'(g))
                code_q[g] <= req.data;
        end
        assign spreading_code_o[g*8 +: 8] = code_q[g];
    end

    // configuration registers, 3 to 8 bits wide
    always_ff @(posedge clk_i)
    begin
        if (clr_all)
        begin
            thr_low_o        <= rbc_pkg::RST_THR_LOW;
            thr_high_o       <= rbc_pkg::RST_THR_HIGH;
            wake_en          <= rbc_pkg::RST_BYTE;
            analog           <= rbc_pkg::RST_BYTE;
            rf_channel_o     <= 7'h00;
            power_amp_bias_o <= 3'h0;
            crystal          <= rbc_pkg::RST_BYTE;
            pwr_ctl          <= rbc_pkg::RST_BYTE;
            carrier          <= rbc_pkg::RST_BYTE;
        end
        else if (wr_ev)
        begin
            case (req.addr)
                rbc_pkg::ADDR_THR_LOW:  thr_low_o <= req.data[6:0];
                rbc_pkg::ADDR_THR_HIGH: thr_high_o <= req.data[6:0];
                rbc_pkg::ADDR_WAKE_EN:  wake_en <= req.data & rbc_pkg::MASK_WAKE;
                rbc_pkg::ADDR_ANALOG:   analog <= req.data & rbc_pkg::MASK_ANALOG;
                rbc_pkg::ADDR_CHANNEL:  rf_channel_o <= req.data[6:0];
                rbc_pkg::ADDR_AMP_BIAS: power_amp_bias_o <= req.data[2:0];
                rbc_pkg::ADDR_CRYSTAL:  crystal <= req.data & rbc_pkg::MASK_7BIT;
                rbc_pkg::ADDR_PWR_CTL:  if (unlock) pwr_ctl <= req.data & rbc_pkg::MASK_TOPBIT;
                rbc_pkg::ADDR_CARRIER:  if (unlock) carrier <= req.data & rbc_pkg::MASK_TOPBIT;
                default: ;
            endcase
        end
    end

    // wake status: a new wakeup beats a clearing read
    always_ff @(posedge clk_i)
    begin
        if (clr_all)
            wake_stat <= rbc_pkg::RST_WAKE_STAT;
        else if (wake_ev)
            wake_stat <= 1'b1;
        else if (wake_rd)
            wake_stat <= 1'b0;
    end

    // read image for the link side
    wire mid_hit = (cur_addr >= rbc_pkg::ADDR_MID_FIRST);
    wire [5:0] mid_sh = {1'b0, cur_addr[1:0]
                         - rbc_pkg::ADDR_MID_FIRST[1:0], 3'h0};
    wire [31:0] mid_word = {2'h0, MID_VALUE} >> mid_sh;
    wire [5:0] rd_idx = cur_addr - rbc_pkg::ADDR_CODE_FIRST;
    always_comb
    begin
        rd_data = rbc_pkg::RST_BYTE;
        if (cur_addr >= rbc_pkg::ADDR_CODE_FIRST
            && cur_addr <= rbc_pkg::ADDR_CODE_LAST)
            rd_data = code_q[rd_idx[2:0]];
        else if (mid_hit)
            rd_data = analog[rbc_pkg::ANA_MID_READ] ? mid_word[7:0]
                      : rbc_pkg::RST_BYTE;
        else
            case (cur_addr)
                rbc_pkg::ADDR_THR_LOW:   rd_data = {1'b0, thr_low_o};
                rbc_pkg::ADDR_THR_HIGH:  rd_data = {1'b0, thr_high_o};
                rbc_pkg::ADDR_WAKE_EN:   rd_data = wake_en;
                rbc_pkg::ADDR_WAKE_STAT: rd_data = {7'h00, wake_stat};
                rbc_pkg::ADDR_ANALOG:    rd_data = analog;
                rbc_pkg::ADDR_CHANNEL:   rd_data = {1'b0, rf_channel_o};
                rbc_pkg::ADDR_STRENGTH:  rd_data = {2'h0, signal_strength_valid_i,
                                                    signal_strength_value_i};
                rbc_pkg::ADDR_AMP_BIAS:  rd_data = {5'h00, power_amp_bias_o};
                rbc_pkg::ADDR_CRYSTAL:   rd_data = crystal;
                rbc_pkg::ADDR_PWR_CTL:   rd_data = pwr_ctl;
                rbc_pkg::ADDR_CARRIER:   rd_data = carrier;
                default:                 rd_data = rbc_pkg::RST_BYTE;
            endcase
    end

    // ---------------- transmit chip sequencer ----------------
    rbc_pkg::rbc_tx_state_type tx_state;
    logic [7:0] data_sh;
    logic [7:0] valid_sh;
    logic [5:0] chip_cnt;
    logic       half_sel;
    wire  half_mode = (code_mode_i != rbc_pkg::RBC_CODE_FULL);
    wire  use_high  = (code_mode_i == rbc_pkg::RBC_CODE_HIGH)
                      || (code_mode_i == rbc_pkg::RBC_CODE_DUAL && half_sel);
    wire  [5:0] chip_idx = half_mode
                           ? ((use_high ? rbc_pkg::CHIP_HIGH_BASE : 6'h00)
                              | chip_cnt)
                           : chip_cnt;
    wire  bit_last  = chip_cnt == (half_mode ? rbc_pkg::CHIP_LAST_HALF
                                             : rbc_pkg::CHIP_LAST_FULL);
    wire  code_bit  = spreading_code_o[chip_idx];
    wire  tx_active = (tx_state == rbc_pkg::RBC_TX_RUN);
    wire  next_chip = valid_sh[0] ? (code_bit ^ ~data_sh[0]) : code_bit;
    wire  load_ok   = tx_load_i && !tx_active && (tx_valid_i != 8'h00);

    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            tx_state <= rbc_pkg::RBC_TX_IDLE;
            data_sh  <= 8'h00;
            valid_sh <= 8'h00;
            chip_cnt <= 6'h00;
            half_sel <= 1'b0;
        end
        else
            case (tx_state)
                rbc_pkg::RBC_TX_IDLE:
                    if (load_ok)
                    begin
                        tx_state <= rbc_pkg::RBC_TX_RUN;
                        data_sh  <= tx_byte_i;
                        valid_sh <= tx_valid_i;
                        chip_cnt <= 6'h00;
                    end
                rbc_pkg::RBC_TX_RUN:
                    if (bit_last)
                    begin
                        chip_cnt <= 6'h00;
                        half_sel <= ~half_sel;
                        data_sh  <= {1'b0, data_sh[7:1]};
                        valid_sh <= {1'b0, valid_sh[7:1]};
                        if (valid_sh[7:1] == 7'h00)
                            tx_state <= rbc_pkg::RBC_TX_IDLE;
                    end
                    else
                        chip_cnt <= chip_cnt + 6'h01;
                default: tx_state <= rbc_pkg::RBC_TX_IDLE;
            endcase
    end

    // registered pins and status
    always_ff @(posedge clk_i)
    begin
        if (srst_i)
        begin
            tx_chip_o                <= 1'b0;
            tx_busy_o                <= 1'b0;
            tx_ready_o               <= 1'b0;
            rx_bit_o                 <= 1'b0;
            rx_bit_valid_o           <= 1'b0;
            rx_bit_miss_o            <= 1'b0;
            wake_irq_o               <= 1'b0;
            synth_freq_mhz_o         <= rbc_pkg::SYNTH_BASE_MHZ;
            crystal_trim_o           <= 6'h00;
            buffered_clock_en_o      <= 1'b0;
            ext_amp_control_pin_o    <= 1'b0;
            ext_amp_control_pin_oe_o <= 1'b0;
            pwr_ctl_bit_o            <= 1'b0;
            carrier_override_o       <= 1'b0;
        end
        else
        begin
            tx_chip_o      <= tx_active && next_chip;
            tx_busy_o      <= tx_active;
            tx_ready_o     <= !tx_active && !load_ok;
            rx_bit_valid_o <= corr_count_valid_i;
            rx_bit_o       <= corr_count_valid_i
                              && corr_count_i >= thr_high_o;
            rx_bit_miss_o  <= corr_count_valid_i
                              && corr_count_i < thr_high_o
                              && corr_count_i > thr_low_o;
            wake_irq_o     <= wake_stat && wake_en[0];
            synth_freq_mhz_o <= rbc_pkg::SYNTH_BASE_MHZ
                                + {5'h00, rf_channel_o};
            crystal_trim_o <= crystal[5:0];
            buffered_clock_en_o <= pd_stable
                                   && !crystal[rbc_pkg::XTAL_CLK_OFF];
            ext_amp_control_pin_oe_o <= analog[rbc_pkg::ANA_AMP_OE];
            ext_amp_control_pin_o <= analog[rbc_pkg::ANA_AMP_INV]
                                     ^ tx_active;
            pwr_ctl_bit_o      <= pwr_ctl[7];
            carrier_override_o <= carrier[7];
        end
    end

    // ---------------- checks ----------------
    sequence s_soft_rst_write;
        wr_ev && req.addr == rbc_pkg::ADDR_ANALOG
        && req.data[rbc_pkg::ANA_SOFT_RST];
    endsequence

    property p_soft_rst;
        @(posedge clk_i) disable iff (srst_i)
        s_soft_rst_write |=> thr_low_o == rbc_pkg::RST_THR_LOW
            && thr_high_o == rbc_pkg::RST_THR_HIGH && wake_stat
            && analog == rbc_pkg::RST_BYTE;
    endproperty
    a_soft_rst: assert property (p_soft_rst)
        else $error("soft reset left a register off its default");

    property p_wake_set;
        @(posedge clk_i) disable iff (srst_i)
        wake_ev && !soft_rst |=> wake_stat;
    endproperty
    a_wake_set: assert property (p_wake_set)
        else $error("wakeup did not set status");

    property p_wake_clear;
        @(posedge clk_i) disable iff (srst_i)
        wake_rd && !wake_ev && !soft_rst |=> !wake_stat;
    endproperty
    a_wake_clear: assert property (p_wake_clear)
        else $error("status read did not clear wake");

    property p_wake_irq;
        @(posedge clk_i) disable iff (srst_i)
        wake_stat && !wake_en[0] |=> !wake_irq_o;
    endproperty
    a_wake_irq: assert property (p_wake_irq)
        else $error("wake interrupt raised while disabled");

    property p_locked;
        @(posedge clk_i) disable iff (srst_i)
        wr_ev && !unlock && req.addr == rbc_pkg::ADDR_PWR_CTL
        |=> $stable(pwr_ctl);
    endproperty
    a_locked: assert property (p_locked)
        else $error("protected register written while locked");

    property p_corr_one;
        @(posedge clk_i) disable iff (srst_i)
        corr_count_valid_i && corr_count_i >= thr_high_o
        |=> rx_bit_valid_o && rx_bit_o && !rx_bit_miss_o;
    endproperty
    a_corr_one: assert property (p_corr_one)
        else $error("count at high threshold not taken as one");

    property p_tx_order;
        @(posedge clk_i) disable iff (srst_i)
        tx_active && !bit_last |=> chip_cnt == $past(chip_cnt) + 6'h01
            ##1 tx_chip_o == $past(next_chip);
    endproperty
    a_tx_order: assert property (p_tx_order)
        else $error("chip order broken");

    property p_tx_stop;
        @(posedge clk_i) disable iff (srst_i)
        tx_active && bit_last && valid_sh[7:1] == 7'h00
        |=> !tx_active ##1 !tx_busy_o;
    endproperty
    a_tx_stop: assert property (p_tx_stop)
        else $error("serializer ran past its last valid bit");

    property p_amp_oe;
        @(posedge clk_i) disable iff (srst_i)
        !analog[rbc_pkg::ANA_AMP_OE] |=> !ext_amp_control_pin_oe_o;
    endproperty
    a_amp_oe: assert property (p_amp_oe)
        else $error("amplifier pin driven while disabled");
endmodule

// ### tb/rbc_host.sv
// serial host model, mode 0, clock runs only inside frames
module rbc_host (
    output logic      sck_o,
    output logic      ss_n_o,
    output logic      mosi_o,
    input  wire logic miso_i
);
    timeunit 1ns;
    timeprecision 1ns;
    initial
    begin
        sck_o = 0;
        ss_n_o = 1;
        mosi_o = 0;
    end
    // command byte then one data byte, msb first, 125 ns per bit
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        ss_n_o = 0;
        #250;
        for (int i = 15; i >= 0; i--)
        begin
            mosi_o = tx[i];
            #62 sck_o = 1;
            if (i < 8)
                rx[i] = miso_i;
            #63 sck_o = 0;
        end
        #100 ss_n_o = 1;
        mosi_o = ~mosi_o; // idle line never repeats the last bit
    endtask
endmodule

// ### tb/rbc_regs_bench.sv
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin errors++; \
    $display("Error %0t: got %h exp %h", $time, a, e); end end
module rbc_regs_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 0, srst_i = 1, sck, ss_n, mosi, miso, pd_n = 1, ld = 0;
    logic cv = 0, chip, busy, rxb, rxv, rxm, wirq, clken, amp, amp_oe, pwr;
    logic [7:0] r;
    logic rdy, car, miso_oe;
    logic [63:0] code, cap;
    logic [6:0] thl, thh;
    logic [5:0] trim;
    rbc_pkg::rbc_code_mode_type mode = rbc_pkg::RBC_CODE_FULL;
    logic [6:0] cnt = 7'h00, chan;
    logic [11:0] freq;
    logic [2:0] bias;
    logic [6:0] cc [3] = '{7'h38, 7'h37, 7'h10};
    logic [1:0] ce [3] = '{2'b10, 2'b01, 2'b00};
    int errors = 0, check_count = 0, ones = 0, n = 0;
    always #50 clk_i = ~clk_i;
    // an undriven data line shows the inverse of miso, which is held at 0 then, so it reads 1
    rbc_host rbc_host_inst (.sck_o(sck), .ss_n_o(ss_n), .mosi_o(mosi),
        .miso_i(miso_oe ? miso : ~miso));
    rbc_regs rbc_regs_inst (.clk_i(clk_i), .srst_i(srst_i), .spi_sck_i(sck),
        .spi_ss_n_i(ss_n), .spi_mosi_i(mosi), .spi_miso_o(miso),
        .spi_miso_oe_o(miso_oe), .power_down_input_n_i(pd_n),
        .code_mode_i(mode), .tx_load_i(ld),
        .tx_byte_i(8'h05), .tx_valid_i(8'h0F), .tx_ready_o(rdy),
        .tx_chip_o(chip), .tx_busy_o(busy), .corr_count_i(cnt),
        .corr_count_valid_i(cv), .rx_bit_o(rxb), .rx_bit_valid_o(rxv),
        .rx_bit_miss_o(rxm), .signal_strength_value_i(5'h15),
        .signal_strength_valid_i(1'b1), .spreading_code_o(code),
        .thr_low_o(thl), .thr_high_o(thh), .wake_irq_o(wirq),
        .rf_channel_o(chan), .synth_freq_mhz_o(freq),
        .power_amp_bias_o(bias), .crystal_trim_o(trim),
        .buffered_clock_en_o(clken), .ext_amp_control_pin_o(amp),
        .ext_amp_control_pin_oe_o(amp_oe), .pwr_ctl_bit_o(pwr),
        .carrier_override_o(car));
    // one serial access, then let the core take it
    task automatic acc(input logic w, input logic [5:0] a,
                       input logic [7:0] d);
        rbc_host_inst.xfer({w, 1'b0, a, d}, r);
        repeat (8) @(negedge clk_i);
    endtask
    // one load pulse, then count chips and capture the first 64
    task automatic send;
        ones = 0;
        n = 0;
        @(posedge clk_i) ld <= 1;
        @(posedge clk_i) ld <= 0;
        repeat (400) @(negedge clk_i)
        begin
            ones += int'(chip & busy);
            if (busy && n < 64)
                cap[n] = chip;
            n += int'(busy);
        end
    endtask
    task automatic summarize;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // register walk, correlator, wakeup, transmit, soft reset
    initial
    begin
        repeat (10) @(posedge clk_i);
        srst_i <= 0;
        repeat (6) @(negedge clk_i);
        acc(0, 6'h19, 0); `CHK(r, 8'h08)
        acc(0, 6'h1A, 0); `CHK(r, 8'h38)
        `CHK({thl, thh}, {7'h08, 7'h38})
        acc(0, 6'h1C, 0); `CHK(r, 8'h00)
        acc(0, 6'h1D, 0); `CHK(r, 8'h01)
        acc(0, 6'h1D, 0); `CHK(r, 8'h00)
        acc(0, 6'h22, 0); `CHK(r, 8'h35)
        acc(1, 6'h21, 8'h05); `CHK(freq, 12'h965)
        acc(1, 6'h2E, 8'h80); `CHK(pwr, 1'b0)
        acc(1, 6'h20, 8'h40); acc(1, 6'h2E, 8'h80); `CHK(pwr, 1'b1)
        acc(1, 6'h2F, 8'h80); `CHK({pwr, car}, 2'b11)
        acc(0, 6'h3C, 0); `CHK(r, 8'h00)
        acc(1, 6'h20, 8'h20); acc(0, 6'h3C, 0); `CHK(r, 8'h67)
        acc(1, 6'h20, 8'h04); `CHK({amp_oe, amp}, 2'b10)
        acc(1, 6'h20, 8'h06); `CHK({amp_oe, amp}, 2'b11)
        acc(1, 6'h23, 8'h07); `CHK(bias, 3'h7)
        `CHK(clken, 1'b1)
        acc(1, 6'h24, 8'h55); `CHK({clken, trim}, 7'h15)
        acc(1, 6'h19, 8'h10);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge clk_i) cnt <= cc[i];
            cv <= 1;
            @(posedge clk_i) cv <= 0;
            @(negedge clk_i) `CHK({rxv, rxb, rxm}, {1'b1, ce[i]})
        end
        acc(1, 6'h1C, 8'h01);
        @(posedge clk_i) pd_n <= 0;
        repeat (10) @(posedge clk_i);
        pd_n <= 1;
        repeat (10) @(negedge clk_i);
        `CHK(wirq, 1'b1)
        acc(0, 6'h1D, 0); `CHK(wirq, 1'b0)
        `CHK(r, 8'h01)
        acc(1, 6'h11, 8'h0B); acc(1, 6'h18, 8'h80);
        acc(0, 6'h18, 0); `CHK(r, 8'h80)
        `CHK(code, 64'h8000_0000_0000_000B)
        send(); `CHK(cap, 64'h8000_0000_0000_000B)
        `CHK(ones, 128)
        `CHK(n, 256)
        `CHK({busy, rdy}, 2'b01)
        @(posedge clk_i) mode <= rbc_pkg::RBC_CODE_DUAL;
        send(); `CHK(ones, 68)
        `CHK(n, 128)
        acc(1, 6'h20, 8'h01); `CHK({chan, thl, code}, {7'h00, 7'h08, 64'h0})
        acc(0, 6'h19, 0); `CHK(r, 8'h08)
        summarize();
    end
endmodule
